// >>> rtl/dlcm_pkg.sv
// Package of codes, reset values and monitor selections for the drive link command monitor.
package dlcm_pkg;
   // Instruction codes.
   localparam logic [7:0] DLCM_CODE_RESET = 8'hFD;
   localparam logic [7:0] DLCM_CODE_MODE_WR = 8'hFB;
   localparam logic [7:0] DLCM_CODE_CLEAR = 8'hFC;
   localparam logic [7:0] DLCM_CODE_EXT_RD = 8'h7F;
   localparam logic [7:0] DLCM_CODE_EXT_WR = 8'hFF;
   localparam logic [7:0] DLCM_CODE_BG_RD = 8'h6C;
   localparam logic [7:0] DLCM_CODE_BG_WR = 8'hEC;
   localparam logic [7:0] DLCM_CODE_GAIN2_WR = 8'h99;
   localparam logic [7:0] DLCM_CODE_GAIN4_WR = 8'h9A;
   localparam logic [7:0] DLCM_CODE_BG_LO = 8'h5E;
   localparam logic [7:0] DLCM_CODE_BG_HI = 8'h61;
   localparam logic [7:0] DLCM_CODE_BGW_LO = 8'hDE;
   localparam logic [7:0] DLCM_CODE_BGW_HI = 8'hE1;
   // Data keys.
   localparam logic [15:0] DLCM_KEY_RESET = 16'h9696;
   localparam logic [15:0] DLCM_KEY_CLR_A = 16'h5A5A;
   localparam logic [15:0] DLCM_KEY_CLR_B = 16'h55AA;
   localparam logic [15:0] DLCM_MODE_NET = 16'h0000;
   localparam logic [15:0] DLCM_EXT_MAX = 16'h0009;
   localparam logic [15:0] DLCM_BG_MAX = 16'h0002;
   // Bias/gain meanings.
   localparam logic [1:0] DLCM_BG_FREQ = 2'h0;
   localparam logic [1:0] DLCM_BG_PARAM = 2'h1;
   localparam logic [1:0] DLCM_BG_TERM = 2'h2;
   // Reply codes.
   localparam logic [15:0] DLCM_REPLY_OK = 16'h0000;
   localparam logic [15:0] DLCM_REPLY_BAD_CODE = 16'h0001;
   localparam logic [15:0] DLCM_REPLY_BAD_DATA = 16'h0003;
   // Monitor codes.
   localparam logic [7:0] DLCM_MON_NONE = 8'h00;
   localparam logic [7:0] DLCM_MON_FREQ = 8'h01;
   localparam logic [7:0] DLCM_MON_CURR = 8'h02;
   localparam logic [7:0] DLCM_MON_VOLT = 8'h03;
   localparam logic [7:0] DLCM_MON_SETF = 8'h05;
   // Layouts that open the extra monitor words.
   localparam logic [7:0] DLCM_LAYOUT_12 = 8'd12;
   localparam logic [7:0] DLCM_LAYOUT_14 = 8'd14;
   localparam logic [7:0] DLCM_LAYOUT_18 = 8'd18;
   // Reset values.
   localparam logic [15:0] DLCM_EXT_RST = 16'h0000;
   localparam logic [1:0] DLCM_BG_RST = 2'h0;
   localparam logic [15:0] DLCM_MON_RST = 16'h0000;
   // Number of monitor slots.
   localparam int DLCM_SLOTS = 6;
endpackage

// >>> rtl/dlcm_mon_mux.sv
// Monitor value selector for one slot, with registered output.
`timescale 1ns/1ps
module dlcm_mon_mux
   import dlcm_pkg::*;
#(
   parameter bit SECOND_SLOT = 1'b0
)
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic ce,
   input wire logic [7:0] code,
   input wire logic [15:0] out_freq,
   input wire logic [15:0] out_curr,
   input wire logic [15:0] out_volt,
   input wire logic [15:0] set_freq,
   output logic [15:0] value_q
);
   logic [15:0] value_d;

   // Frequency codes report raw 0.01 Hz counts, never display scaling; code 00 reads zero outside the second slot.
   // RULE10 RULE11 RULE13 frequency codes
   always_comb
   begin
      case (code)
         DLCM_MON_NONE: value_d = SECOND_SLOT ? out_freq : 16'h0000;
         DLCM_MON_FREQ: value_d = out_freq;
         DLCM_MON_CURR: value_d = out_curr;
         DLCM_MON_VOLT: value_d = out_volt;
         DLCM_MON_SETF: value_d = set_freq;
         default: value_d = 16'h0000;
      endcase
   end

   // Registered so the master never sees a half-switched selection.
   always_ff @(posedge mclk)
   begin
      if (rst)
         value_q <= 16'h0000;
      else if (ce)
         value_q <= value_d;
   end
endmodule

// >>> rtl/dlcm_core.sv
// Instruction code interpreter and monitor selector of the drive link option.
// Overview of operation
// RULE1: Code FD with data 9696 performs a complete drive reset.
// RULE2: Extension setting 0000..0009 is readable and writable, maps parameter codes.
// RULE3: Bias/gain selector: 00 frequency, 01 parameter analog, 02 terminal analog.
// RULE4: Extension write by code only when layout is zero, else from write register.
// RULE5: Gain frequencies also writable through codes 99 and 9A.
// RULE6: Monitor word low byte picks first value, high byte picks second.
// RULE7: Word 0302 selects current first and voltage second.
// RULE8: Layouts 12, 14, 18 alone accept monitor words three to six.
// RULE9: Code 00 gives frequency in second slot, zero in others.
// RULE10: Codes 00, 01, 05 always report frequency, ignoring display settings; here code 00 reads zero outside the second slot.
// RULE11: Output frequency value is unsigned binary in 0.01 Hz units.
// RULE12: Code FB with data 0000 switches the drive to network operation.
// RULE13: Monitor code 01 selects output frequency.
// RULE14: Power loss during clear 5A5A or 55AA also clears communication parameters.
// RULE15: Reset by code accepted only if startup mode nonzero or network mode.
// RULE16: Master waits for completion and zero reply before next frequency.
// RULE17: Execute on rising request; reply and done held until request clears.
`timescale 1ns/1ps
module dlcm_core
   import dlcm_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic ce,
   input wire logic instruction_execute_request,
   input wire logic [7:0] instr_code,
   input wire logic [15:0] instr_data,
   input wire logic [7:0] register_layout_select,
   input wire logic [15:0] ext_from_register,
   input wire logic [7:0] startup_mode_select,
   input wire logic power_lost,
   input wire logic [15:0] monitor_select_word,
   input wire logic [63:0] extra_monitor_select_words,
   input wire logic [15:0] out_freq,
   input wire logic [15:0] out_curr,
   input wire logic [15:0] out_volt,
   input wire logic [15:0] set_freq,
   output logic instr_done_q,
   output logic [15:0] reply_code_q,
   output logic [15:0] read_data_q,
   output logic drive_reset_q,
   output logic net_mode_q,
   output logic [15:0] ext_setting_q,
   output logic [1:0] bias_gain_sel_q,
   output logic gain_write_q,
   output logic gain_terminal4_q,
   output logic [15:0] gain_data_q,
   output logic clear_busy_q,
   output logic comm_param_clear_q,
   output logic [15:0] first_monitor_value,
   output logic [15:0] second_monitor_value,
   output logic [63:0] extra_monitor_values
);
   typedef enum logic [2:0] {
      DLCM_IDLE = 3'b001,
      DLCM_EXEC = 3'b010,
      DLCM_HOLD = 3'b100
   } dlcm_state_e;

   dlcm_state_e state_q;
   logic req_q;
   logic [15:0] ext_word_q;
   logic ext_wr_ok;
   logic extra_open;
   logic [15:0] reply_d;
   logic [15:0] rdata_d;
   logic [7:0] slot_code [DLCM_SLOTS];
   logic [15:0] slot_val [DLCM_SLOTS];

   // RULE4 layout gate
   assign ext_wr_ok = (register_layout_select == 8'h00);
   // RULE8 extra words gate
   assign extra_open = (register_layout_select == DLCM_LAYOUT_12)
      || (register_layout_select == DLCM_LAYOUT_14)
      || (register_layout_select == DLCM_LAYOUT_18);

   // Request edge detector; only a rising request starts work.
   always_ff @(posedge mclk)
   begin
      if (rst)
         req_q <= 1'b0;
      else if (ce)
         req_q <= instruction_execute_request;
   end

   // RULE17 handshake sequence
   always_ff @(posedge mclk)
   begin
      if (rst)
         state_q <= DLCM_IDLE;
      else if (ce)
      begin
         case (state_q)
            DLCM_IDLE: if (instruction_execute_request && !req_q) state_q <= DLCM_EXEC;
            DLCM_EXEC: state_q <= DLCM_HOLD;
            DLCM_HOLD: if (!instruction_execute_request) state_q <= DLCM_IDLE;
            default: state_q <= DLCM_IDLE;
         endcase
      end
   end

   // Reply and read data for the current instruction, decided in one place.
   always_comb
   begin
      reply_d = DLCM_REPLY_OK;
      rdata_d = 16'h0000;
      case (instr_code)
         // RULE1 drive reset key
         DLCM_CODE_RESET:
            if (instr_data != DLCM_KEY_RESET) reply_d = DLCM_REPLY_BAD_DATA;
            // RULE15 reset acceptance
            else if (startup_mode_select == 8'h00 && !net_mode_q)
               reply_d = DLCM_REPLY_BAD_CODE;
         // RULE12 network mode
         DLCM_CODE_MODE_WR:
            if (instr_data != DLCM_MODE_NET) reply_d = DLCM_REPLY_BAD_DATA;
         DLCM_CODE_CLEAR:
            if (instr_data != DLCM_KEY_CLR_A && instr_data != DLCM_KEY_CLR_B
               && instr_data != DLCM_KEY_RESET)
               reply_d = DLCM_REPLY_BAD_DATA;
         // RULE2 extension range
         DLCM_CODE_EXT_WR:
            if (instr_data > DLCM_EXT_MAX) reply_d = DLCM_REPLY_BAD_DATA;
         DLCM_CODE_EXT_RD: rdata_d = ext_setting_q;
         // RULE3 selector range
         DLCM_CODE_BG_WR:
            if (instr_data > DLCM_BG_MAX) reply_d = DLCM_REPLY_BAD_DATA;
         DLCM_CODE_BG_RD: rdata_d = {14'h0000, bias_gain_sel_q};
         DLCM_CODE_GAIN2_WR, DLCM_CODE_GAIN4_WR: reply_d = DLCM_REPLY_OK;
         default:
            if (!((instr_code >= DLCM_CODE_BG_LO && instr_code <= DLCM_CODE_BG_HI)
               || (instr_code >= DLCM_CODE_BGW_LO && instr_code <= DLCM_CODE_BGW_HI)))
               reply_d = DLCM_REPLY_BAD_CODE;
      endcase
   end

   // RULE17 reply capture
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         reply_code_q <= DLCM_REPLY_OK;
         read_data_q <= 16'h0000;
      end
      else if (ce && state_q == DLCM_EXEC)
      begin
         reply_code_q <= reply_d;
         read_data_q <= rdata_d;
      end
   end

   // RULE17 done flag
   always_ff @(posedge mclk)
   begin
      if (rst)
         instr_done_q <= 1'b0;
      else if (ce)
         instr_done_q <= (state_q == DLCM_EXEC) || (state_q == DLCM_HOLD
            && instruction_execute_request);
   end

   // RULE1 reset pulse
   always_ff @(posedge mclk)
   begin
      if (rst)
         drive_reset_q <= 1'b0;
      else if (ce)
         drive_reset_q <= state_q == DLCM_EXEC && instr_code == DLCM_CODE_RESET
            && reply_d == DLCM_REPLY_OK;
   end

   // RULE12 network mode latch
   always_ff @(posedge mclk)
   begin
      if (rst)
         net_mode_q <= 1'b0;
      else if (ce && state_q == DLCM_EXEC && instr_code == DLCM_CODE_MODE_WR
         && reply_d == DLCM_REPLY_OK)
         net_mode_q <= 1'b1;
   end

   // Extension word written by instruction; survives a layout change.
   always_ff @(posedge mclk)
   begin
      if (rst)
         ext_word_q <= DLCM_EXT_RST;
      // RULE4 code write gated
      else if (ce && state_q == DLCM_EXEC && instr_code == DLCM_CODE_EXT_WR
         && reply_d == DLCM_REPLY_OK && ext_wr_ok)
         ext_word_q <= instr_data;
   end

   // RULE4 extension source
   always_ff @(posedge mclk)
   begin
      if (rst)
         ext_setting_q <= DLCM_EXT_RST;
      else if (ce)
         ext_setting_q <= ext_wr_ok ? ext_word_q : ext_from_register;
   end

   // RULE3 selector write
   always_ff @(posedge mclk)
   begin
      if (rst)
         bias_gain_sel_q <= DLCM_BG_RST;
      else if (ce && state_q == DLCM_EXEC && instr_code == DLCM_CODE_BG_WR
         && reply_d == DLCM_REPLY_OK)
         bias_gain_sel_q <= instr_data[1:0];
   end

   // RULE5 gain frequency writes
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         gain_write_q <= 1'b0;
         gain_terminal4_q <= 1'b0;
         gain_data_q <= 16'h0000;
      end
      else if (ce)
      begin
         gain_write_q <= state_q == DLCM_EXEC && (instr_code == DLCM_CODE_GAIN2_WR
            || instr_code == DLCM_CODE_GAIN4_WR);
         // Gain data only moves on gain codes, so other instructions leave it alone.
         if (state_q == DLCM_EXEC && (instr_code == DLCM_CODE_GAIN2_WR
            || instr_code == DLCM_CODE_GAIN4_WR))
         begin
            gain_terminal4_q <= instr_code == DLCM_CODE_GAIN4_WR;
            gain_data_q <= instr_data;
         end
      end
   end

   // RULE14 clear in progress and power loss
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         clear_busy_q <= 1'b0;
         comm_param_clear_q <= 1'b0;
      end
      else if (ce)
      begin
         if (state_q == DLCM_EXEC && instr_code == DLCM_CODE_CLEAR
            && (instr_data == DLCM_KEY_CLR_A || instr_data == DLCM_KEY_CLR_B))
            clear_busy_q <= 1'b1;
         else if (state_q == DLCM_IDLE)
            clear_busy_q <= 1'b0;
         comm_param_clear_q <= clear_busy_q && power_lost;
      end
   end

   // RULE6 RULE7 byte split
   assign slot_code[0] = monitor_select_word[7:0];
   assign slot_code[1] = monitor_select_word[15:8];

   // One selector per slot; extra slots read zero unless the layout opens them.
   genvar g;
   generate
      for (g = 0; g < DLCM_SLOTS; g++)
      begin : g_slot
         if (g >= 2)
         begin : g_extra
            // RULE8 extra slot codes
            assign slot_code[g] = extra_open ? extra_monitor_select_words[(g-2)*16 +: 8]
               : DLCM_MON_NONE;
            assign extra_monitor_values[(g-2)*16 +: 16] = slot_val[g];
         end
         // RULE9 slot specific zero
         dlcm_mon_mux #(.SECOND_SLOT(g == 1)) u_mux (
            .mclk(mclk),
            .rst(rst),
            .ce(ce),
            .code(slot_code[g]),
            .out_freq(out_freq),
            .out_curr(out_curr),
            .out_volt(out_volt),
            .set_freq(set_freq),
            .value_q(slot_val[g])
         );
      end
   endgenerate

   assign first_monitor_value = slot_val[0];
   assign second_monitor_value = slot_val[1];

   sequence req_rise_s;
      !req_q && instruction_execute_request && state_q == DLCM_IDLE && ce;
   endsequence
   sequence done_s;
      ce ##1 instr_done_q;
   endsequence

   done_after_a: assert property (@(posedge mclk) disable iff (rst) // RULE17
      req_rise_s ##1 ce |-> done_s) else $error("done not raised after request");
   done_hold_a: assert property (@(posedge mclk) disable iff (rst) // RULE17
      instr_done_q && !instruction_execute_request && ce && state_q == DLCM_HOLD
      |=> !instr_done_q) else $error("done not dropped");
   reset_gate_a: assert property (@(posedge mclk) disable iff (rst) // RULE15
      drive_reset_q |-> $past(startup_mode_select) != 8'h00 || $past(net_mode_q))
      else $error("reset accepted without permission");
   reset_key_a: assert property (@(posedge mclk) disable iff (rst) // RULE1
      drive_reset_q |-> $past(instr_data) == DLCM_KEY_RESET)
      else $error("reset without key");
   net_mode_a: assert property (@(posedge mclk) disable iff (rst) // RULE12
      ce && state_q == DLCM_EXEC && instr_code == DLCM_CODE_MODE_WR
      && instr_data == DLCM_MODE_NET |=> net_mode_q) else $error("network mode missed");
   ext_range_a: assert property (@(posedge mclk) disable iff (rst) // RULE2
      ext_wr_ok |-> ext_word_q <= DLCM_EXT_MAX) else $error("extension out of range");
   ext_source_a: assert property (@(posedge mclk) disable iff (rst) // RULE4
      ce && !ext_wr_ok |=> ext_setting_q == $past(ext_from_register))
      else $error("extension not from register");
   bg_range_a: assert property (@(posedge mclk) disable iff (rst) // RULE3
      bias_gain_sel_q <= DLCM_BG_TERM) else $error("selector out of range");
   slot_zero_a: assert property (@(posedge mclk) disable iff (rst) // RULE9
      ce && monitor_select_word[7:0] == DLCM_MON_NONE |=> first_monitor_value == 16'h0000)
      else $error("first slot not zero");
   slot_freq_a: assert property (@(posedge mclk) disable iff (rst) // RULE10
      ce && monitor_select_word[15:8] == DLCM_MON_NONE |=> second_monitor_value
      == $past(out_freq)) else $error("second slot not frequency");
   extra_closed_a: assert property (@(posedge mclk) disable iff (rst) // RULE8
      ce && !extra_open |=> extra_monitor_values == 64'h0000_0000_0000_0000)
      else $error("extra slots open");
endmodule

// >>> testbench/dlcm_master.sv
// Master station model that issues instruction codes over the request handshake.
`timescale 1ns/1ps
module dlcm_master
(
   input wire logic mclk,
   input wire logic instr_done_q,
   input wire logic [15:0] reply_code_q,
   input wire logic [15:0] read_data_q,
   output logic instruction_execute_request,
   output logic [7:0] instr_code,
   output logic [15:0] instr_data
);
   // The bus starts idle with the request low.
   initial
   begin
      instruction_execute_request = 1'b0;
      instr_code = 8'h00;
      instr_data = 16'h0000;
   end

   // request, wait, release
   // Code and data are inverted on release so stale values never look valid.
   task automatic issue(input logic [7:0] code, input logic [15:0] data,
                        output logic [15:0] reply, output logic [15:0] rdata, output bit ok);
      int n;
      bit held;
      begin
         n = 0;
         @(negedge mclk);
         instr_code = code;
         instr_data = data;
         instruction_execute_request = 1'b1;
         while (instr_done_q !== 1'b1 && n < 20)
         begin
            @(negedge mclk);
            n++;
         end
         reply = reply_code_q;
         rdata = read_data_q;
         // The flag must stand while the request is still held.
         repeat (3) @(negedge mclk);
         held = (instr_done_q === 1'b1);
         instruction_execute_request = 1'b0;
         instr_code = ~code;
         instr_data = ~data;
         n = 0;
         while (instr_done_q !== 1'b0 && n < 20)
         begin
            @(negedge mclk);
            n++;
         end
         ok = held && (instr_done_q === 1'b0);
      end
   endtask
endmodule

// >>> testbench/test_drive_link_command_monitor.sv
// Self-checking bench for the drive link command monitor.
`timescale 1ns/1ps
module test_drive_link_command_monitor;
   import dlcm_pkg::*;
   logic mclk, rst, ce, req, power_lost;
   logic [7:0] code, layout, startup;
   logic [15:0] data, ext_reg, mon_word, f, cu, vo, sf;
   logic [63:0] extra_words;
   logic done, drv_rst, net_mode, gain_wr, gain_t4, clr_busy, comm_clr;
   logic [15:0] reply, rdata, ext_set, gain_data, mon1, mon2, rd;
   logic [1:0] bg_sel;
   logic [63:0] extra_vals;
   int n_fail = 0, total_checks = 0, n_rst_pulse = 0, n_gain_pulse = 0, n_comm_clr = 0;

   dlcm_core i_dut (.mclk(mclk), .rst(rst), .ce(ce), .instruction_execute_request(req),
      .instr_code(code), .instr_data(data), .register_layout_select(layout),
      .ext_from_register(ext_reg), .startup_mode_select(startup), .power_lost(power_lost),
      .monitor_select_word(mon_word), .extra_monitor_select_words(extra_words),
      .out_freq(f), .out_curr(cu), .out_volt(vo), .set_freq(sf), .instr_done_q(done),
      .reply_code_q(reply), .read_data_q(rdata), .drive_reset_q(drv_rst),
      .net_mode_q(net_mode), .ext_setting_q(ext_set), .bias_gain_sel_q(bg_sel),
      .gain_write_q(gain_wr), .gain_terminal4_q(gain_t4), .gain_data_q(gain_data),
      .clear_busy_q(clr_busy), .comm_param_clear_q(comm_clr),
      .first_monitor_value(mon1), .second_monitor_value(mon2), .extra_monitor_values(extra_vals));

   dlcm_master i_master (.mclk(mclk), .instr_done_q(done), .reply_code_q(reply),
      .read_data_q(rdata), .instruction_execute_request(req), .instr_code(code),
      .instr_data(data));

   // Clock at 40 MHz.
   initial
   begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end

   // Reset and gain pulses last one cycle, so they are counted at every rising edge; the comm clear count covers every cycle it stands.
   always @(posedge mclk)
   begin
      if (drv_rst === 1'b1) n_rst_pulse++;
      if (gain_wr === 1'b1) n_gain_pulse++;
      if (comm_clr === 1'b1) n_comm_clr++;
   end

   task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk64(input logic [63:0] got, input logic [63:0] exp);
      chk16(got[15:0], exp[15:0]);
      chk16(got[31:16], exp[31:16]);
      chk16(got[47:32], exp[47:32]);
      chk16(got[63:48], exp[63:48]);
   endtask

   task automatic report_and_stop();
      $display("Checks %0d, mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // One instruction through the master; a hung handshake ends the run.
   task automatic run(input logic [7:0] c, input logic [15:0] d, input logic [15:0] exp_reply);
      logic [15:0] r;
      bit ok;
      i_master.issue(c, d, r, rd, ok);
      if (!ok)
      begin
         n_fail++;
         $display("Error at %0t: handshake timed out", $time);
         report_and_stop();
      end
      else
         chk16(r, exp_reply);
   endtask

   task automatic mon(input logic [15:0] w, input logic [15:0] e1, input logic [15:0] e2);
      mon_word = w;
      repeat (2) @(negedge mclk);
      chk16(mon1, e1);
      chk16(mon2, e2);
   endtask

   task automatic scen_mode_and_reset();
      run(DLCM_CODE_RESET, DLCM_KEY_RESET, DLCM_REPLY_BAD_CODE);
      chk16(16'(n_rst_pulse), 16'h0000);
      startup = 8'h01;
      run(DLCM_CODE_RESET, 16'h9669, DLCM_REPLY_BAD_DATA);
      run(DLCM_CODE_RESET, DLCM_KEY_RESET, DLCM_REPLY_OK);
      chk16(16'(n_rst_pulse), 16'h0001);
      startup = 8'h00;
      run(DLCM_CODE_MODE_WR, 16'h0001, DLCM_REPLY_BAD_DATA);
      chk16(16'(net_mode), 16'h0000);
      run(DLCM_CODE_MODE_WR, DLCM_MODE_NET, DLCM_REPLY_OK);
      chk16(16'(net_mode), 16'h0001);
      run(DLCM_CODE_RESET, DLCM_KEY_RESET, DLCM_REPLY_OK);
      chk16(16'(n_rst_pulse), 16'h0002);
   endtask

   task automatic scen_ext_and_bias();
      run(DLCM_CODE_EXT_WR, DLCM_EXT_MAX, DLCM_REPLY_OK);
      run(DLCM_CODE_EXT_WR, 16'h000A, DLCM_REPLY_BAD_DATA);
      run(DLCM_CODE_EXT_RD, 16'h0000, DLCM_REPLY_OK);
      chk16(rd, DLCM_EXT_MAX);
      layout = 8'd5;
      run(DLCM_CODE_EXT_WR, 16'h0001, DLCM_REPLY_OK);
      chk16(ext_set, 16'h0004);
      layout = 8'd0;
      // The refused code write must not have reached the stored word.
      repeat (2) @(negedge mclk);
      chk16(ext_set, DLCM_EXT_MAX);
      run(DLCM_CODE_BGW_HI, 16'h0000, DLCM_REPLY_OK);
      for (int i = 0; i < 3; i++)
      begin
         run(DLCM_CODE_BG_WR, 16'(i), DLCM_REPLY_OK);
         run(DLCM_CODE_BG_RD, 16'h0000, DLCM_REPLY_OK);
         chk16(rd, 16'(i));
      end
      run(DLCM_CODE_BG_WR, 16'h0003, DLCM_REPLY_BAD_DATA);
      chk16(16'(bg_sel), 16'h0002);
   endtask

   task automatic scen_gain_and_clear();
      run(DLCM_CODE_GAIN2_WR, 16'h1234, DLCM_REPLY_OK);
      chk16(gain_data, 16'h1234);
      chk16(16'(gain_t4), 16'h0000);
      run(DLCM_CODE_GAIN4_WR, 16'h2345, DLCM_REPLY_OK);
      chk16(gain_data, 16'h2345);
      chk16(16'(gain_t4), 16'h0001);
      chk16(16'(n_gain_pulse), 16'h0002);
      run(DLCM_CODE_CLEAR, DLCM_KEY_CLR_A, DLCM_REPLY_OK);
      // Busy still stands for the edge that returns the engine to idle, then drops.
      chk16(16'(clr_busy), 16'h0001);
      @(negedge mclk);
      chk16(16'(clr_busy), 16'h0000);
      chk16(16'(n_comm_clr), 16'h0000);
      power_lost = 1'b1;
      run(DLCM_CODE_CLEAR, DLCM_KEY_CLR_B, DLCM_REPLY_OK);
      chk16(16'(n_comm_clr > 0), 16'h0001);
      power_lost = 1'b0;
   endtask

   task automatic scen_monitors();
      logic [7:0] lays [5] = '{8'd12, 8'd14, 8'd18, 8'd0, 8'd13};
      mon(16'h0302, cu, vo);
      mon(16'h0000, 16'h0000, f);
      mon(16'h0101, f, f);
      mon(16'h0505, sf, sf);
      // With the clock enable low the slots must keep their old values.
      ce = 1'b0;
      mon(16'h0302, sf, sf);
      ce = 1'b1;
      extra_words = 64'h0000_0003_0002_0001;
      for (int i = 0; i < 5; i++)
      begin
         layout = lays[i];
         repeat (2) @(negedge mclk);
         chk64(extra_vals, (i < 3) ? {16'h0000, vo, cu, f} : 64'h0);
      end
      layout = 8'd0;
   endtask

   // Stimulus changes on falling edges only.
   initial
   begin
      rst = 1'b1;
      ce = 1'b1;
      power_lost = 1'b0;
      layout = 8'd0;
      startup = 8'h00;
      ext_reg = 16'h0004;
      mon_word = 16'h0000;
      extra_words = 64'h0;
      f = 16'h1770;
      cu = 16'h0123;
      vo = 16'h0456;
      sf = 16'h0789;
      repeat (7) @(negedge mclk);
      rst = 1'b0;
      @(negedge mclk);
      chk16({13'h0, done, net_mode, drv_rst}, 16'h0000);
      chk16(ext_set, DLCM_EXT_RST);
      scen_mode_and_reset();
      scen_ext_and_bias();
      scen_gain_and_clear();
      scen_monitors();
      report_and_stop();
   end
endmodule
